// ===== rtl/mw_link_master.sv
// What this block does
// - Shift 16-bit frames: command then data byte
// - Idle link shifts continuous all-ones frames
// - Event when frame moves holding to shifter
// - Add 04H to command after each queue
// - Command low byte, data high, loaded together
// - Reads discard first two received words
// - Read data captured after its frame shifts
// - After last command reload holding with ones
// - N words take N plus two events
// - Release select after final frame leaves shifter
// - Frame time set by link clock rate
// - Next frame queued within one frame time
`default_nettype none
module mw_link_master #(
    parameter int WORDS_MAX = 256,
    parameter int AW        = 8
) (
    // System clock and reset
    input  wire logic          clk_in,
    input  wire logic          nrst_in,
    // Link clock
    input  wire logic          sclk_in,
    // Transfer request
    input  wire logic          start_in,
    input  wire logic          read_in,
    input  wire logic [7:0]    command_byte_in,
    input  wire logic [AW-1:0] word_count_in,
    output logic               busy_out,
    output logic               done_out,
    // Write data buffer fill and read data buffer fetch
    input  wire logic          wr_we_in,
    input  wire logic [AW-1:0] wr_addr_in,
    input  wire logic [7:0]    wr_data_in,
    input  wire logic [AW-1:0] rd_addr_in,
    output logic [7:0]         rd_data_out,
    // Serial pins
    output logic               port_shift_clock_out,
    output logic               bidir_serial_line_out,
    input  wire logic          bidir_serial_line_in,
    output logic               csel_n_out
);
    // Buffers cannot hold more words than the count can name
    if (WORDS_MAX < 1 || WORDS_MAX > (1 << AW)) begin : g_bad_size
        $error("WORDS_MAX does not fit AW");
    end

    mw_xfer_if xif ();

    mw_shifter u_shift (
        .sclk_in  (sclk_in),
        .nrst_in  (nrst_in),
        .xif      (xif),
        .miso_in  (bidir_serial_line_in),
        .mosi_out (bidir_serial_line_out)
    );

    assign port_shift_clock_out = sclk_in;

    logic [7:0]  wbuf [WORDS_MAX];
    logic [7:0]  rbuf [WORDS_MAX];

    logic [2:0]  dtg_ff;
    logic        ev;
    mw_link_pkg::xfer_state_e st_ff;
    logic [7:0]  cmd_ff;
    logic [AW:0] left_ff;
    logic [AW:0] evcnt_ff;
    logic [AW:0] total_ff;
    logic [AW-1:0] wptr_ff;
    logic [AW-1:0] rptr_ff;
    logic        rd_ff;
    logic        ltg_ff;
    logic [15:0] lword_ff;
    logic        cs_n_ff;
    logic        done_ff;
    logic [7:0]  rdo_ff;

    // Event arrives from link domain as a toggle
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dtg_ff <= 3'h0;
        end else begin
            dtg_ff <= {dtg_ff[1:0], xif.done_tgl};
        end
    end
    assign ev = dtg_ff[2] != dtg_ff[1];

    always_ff @(posedge clk_in) begin
        if (wr_we_in) begin
            wbuf[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdo_ff <= 8'h00;
        end else begin
            rdo_ff <= rbuf[rd_addr_in];
        end
    end

    // Sequencer: each event in ST_RUN queues the next frame at once,
    // well inside one frame time
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_ff    <= mw_link_pkg::ST_IDLE;
            cmd_ff   <= 8'h00;
            left_ff  <= '0;
            evcnt_ff <= '0;
            total_ff <= '0;
            wptr_ff  <= '0;
            rptr_ff  <= '0;
            rd_ff    <= 1'b0;
            ltg_ff   <= 1'b0;
            lword_ff <= mw_link_pkg::IDLE_FRAME;
            cs_n_ff  <= 1'b1;
            done_ff  <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            unique case (st_ff)
                mw_link_pkg::ST_IDLE: begin
                    if (start_in && word_count_in != '0) begin
                        cmd_ff   <= command_byte_in;
                        left_ff  <= {1'b0, word_count_in};
                        total_ff <= {1'b0, word_count_in}
                                    + (AW+1)'(mw_link_pkg::PIPE_EXTRA);
                        evcnt_ff <= '0;
                        wptr_ff  <= '0;
                        rptr_ff  <= '0;
                        rd_ff    <= read_in;
                        cs_n_ff  <= 1'b0;
                        st_ff    <= mw_link_pkg::ST_RUN;
                    end
                end
                mw_link_pkg::ST_RUN: begin
                    if (ev) begin
                        evcnt_ff <= evcnt_ff + 1'b1;
                        // Read data of the frame that just left
                        if (rd_ff && evcnt_ff >= (AW+1)'(2)) begin
                            rptr_ff <= rptr_ff + 1'b1;
                        end
                        if (left_ff != '0) begin
                            lword_ff <= {wbuf[wptr_ff], cmd_ff};
                            cmd_ff   <= cmd_ff
                                        + mw_link_pkg::CMD_ADDR_STEP;
                            wptr_ff  <= wptr_ff + 1'b1;
                            left_ff  <= left_ff - 1'b1;
                            ltg_ff   <= ~ltg_ff;
                        end else begin
                            // Last frame is in the shifter now
                            lword_ff <= mw_link_pkg::IDLE_FRAME;
                            ltg_ff   <= ~ltg_ff;
                            st_ff    <= mw_link_pkg::ST_DRAIN;
                        end
                    end
                end
                mw_link_pkg::ST_DRAIN: begin
                    if (ev && evcnt_ff + (AW+1)'(1) == total_ff) begin
                        evcnt_ff <= evcnt_ff + 1'b1;
                        if (rd_ff) begin
                            rptr_ff <= rptr_ff + 1'b1;
                        end
                        // Final frame out, ones shifting
                        cs_n_ff <= 1'b1;
                        done_ff <= 1'b1;
                        st_ff   <= mw_link_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Read capture: write frames' rx is ignored
    always_ff @(posedge clk_in) begin
        if (ev && rd_ff && st_ff != mw_link_pkg::ST_IDLE
            && evcnt_ff >= (AW+1)'(2)) begin
            rbuf[rptr_ff] <= xif.rx_word[15:8];
        end
    end

    assign xif.load_tgl  = ltg_ff;
    assign xif.load_word = lword_ff;
    assign csel_n_out    = cs_n_ff;
    assign busy_out      = st_ff != mw_link_pkg::ST_IDLE;
    assign done_out      = done_ff;
    assign rd_data_out   = rdo_ff;
endmodule
`default_nettype wire

// ===== rtl/mw_link_pkg.sv
`default_nettype none
package mw_link_pkg;
    localparam int          FRAME_BITS     = 16;
    localparam int          BYTE_BITS      = 8;
    localparam logic [7:0]  CMD_ADDR_STEP  = 8'h04;
    localparam logic [15:0] IDLE_FRAME     = 16'hFFFF;
    localparam int          PIPE_EXTRA     = 2;
    localparam int          SYNC_STAGES    = 3;
    // Serial timing figures, kept for reference except BIT_LAST, which the shifter uses; the bench does not use them
    localparam int          BASE_CLK_HZ    = 4_000_000;
    localparam int          FRAME_FAST_US  = 96;
    localparam int          FRAME_SLOW_US  = 192;
    localparam int          CLK_HZ         = 25_000_000;
    localparam int          FRAME_FAST_CYC = FRAME_FAST_US * (CLK_HZ / 1_000_000);
    localparam int          FRAME_SLOW_CYC = FRAME_SLOW_US * (CLK_HZ / 1_000_000);
    localparam logic [3:0]  BIT_LAST       = 4'hF;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_DRAIN
    } xfer_state_e;
endpackage
`default_nettype wire

// ===== rtl/mw_xfer_if.sv
`default_nettype none
// Event crossing between the system side and the link side
interface mw_xfer_if;
    logic        load_tgl;
    logic [15:0] load_word;
    logic        done_tgl;
    logic [15:0] rx_word;
    modport ctl  (output load_tgl, output load_word,
                  input done_tgl, input rx_word);
    modport link (input load_tgl, input load_word,
                  output done_tgl, output rx_word);
endinterface
`default_nettype wire

// ===== rtl/mw_shifter.sv
`default_nettype none
// Link-clock shifter: holding register plus shift register
module mw_shifter (
    // Link clock and reset
    input  wire logic  sclk_in,
    input  wire logic  nrst_in,
    // Crossing to control side
    mw_xfer_if.link    xif,
    // Serial pins
    input  wire logic  miso_in,
    output logic       mosi_out
);
    logic [2:0]  ltg_ff;
    logic [15:0] hold_ff;
    logic [15:0] shift_ff;
    logic [15:0] rx_ff;
    logic [15:0] rxw_ff;
    logic [3:0]  bit_ff;
    logic        done_ff;

    // Three stages; only stages two and three are compared
    always_ff @(posedge sclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ltg_ff <= 3'h0;
        end else begin
            ltg_ff <= {ltg_ff[1:0], xif.load_tgl};
        end
    end

    always_ff @(posedge sclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hold_ff <= mw_link_pkg::IDLE_FRAME;
        end else if (ltg_ff[2] != ltg_ff[1]) begin
            hold_ff <= xif.load_word;
        end else if (bit_ff == mw_link_pkg::BIT_LAST) begin
            // Empty holding register shifts idle ones next
            hold_ff <= mw_link_pkg::IDLE_FRAME;
        end
    end

    always_ff @(posedge sclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            shift_ff <= mw_link_pkg::IDLE_FRAME;
            rx_ff    <= 16'h0000;
            rxw_ff   <= 16'h0000;
            bit_ff   <= 4'h0;
            done_ff  <= 1'b0;
        end else begin
            bit_ff <= bit_ff + 4'h1;
            rx_ff  <= {miso_in, rx_ff[15:1]};
            if (bit_ff == mw_link_pkg::BIT_LAST) begin
                shift_ff <= hold_ff;
                rxw_ff   <= {miso_in, rx_ff[15:1]};
                done_ff  <= ~done_ff;
            end else begin
                shift_ff <= {1'b1, shift_ff[15:1]};
            end
        end
    end

    // LSB first: command byte leaves before data byte
    assign mosi_out     = shift_ff[0];
    assign xif.done_tgl = done_ff;
    assign xif.rx_word  = rxw_ff;
endmodule
`default_nettype wire

// ===== test/mw_link_master_monitor.sv
`default_nettype none
module mw_link_master_monitor #(
    parameter int AW = 8
) (
    // Clock, reset and request
    input wire logic          clk_in,
    input wire logic          nrst_in,
    input wire logic          sclk_in,
    input wire logic          start_in,
    input wire logic [AW-1:0] word_count_in,
    // Status and pins
    input wire logic          busy_out,
    input wire logic          done_out,
    input wire logic          port_shift_clock_out,
    input wire logic          bidir_serial_line_out,
    input wire logic          csel_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Frame of 16 link bits at 30 ns is 12 system cycles
    int              cyc_ff;
    logic [AW-1:0]   n_ff;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cyc_ff <= 0;
            n_ff   <= '0;
        end else if (start_in && !busy_out) begin
            cyc_ff <= 0;
            n_ff   <= word_count_in;
        end else begin
            cyc_ff <= cyc_ff + 1;
        end
    end
    a_start_taken: assert property (start_in && !busy_out &&
        word_count_in != 0 |=> busy_out) else $error("start not taken");
    a_zero_refused: assert property (start_in && !busy_out &&
        word_count_in == 0 |=> !busy_out) else $error("zero count taken");
    a_select_low: assert property ($rose(busy_out) |-> ##[0:2]
        !csel_n_out) else $error("select not lowered");
    a_done_release: assert property (done_out |->
        $rose(csel_n_out)) else $error("done without release");
    a_release_done: assert property ($rose(csel_n_out) |->
        done_out) else $error("select released early");
    a_done_pulse: assert property (done_out |=>
        !done_out) else $error("done longer than one cycle");
    a_idle_ones: assert property (csel_n_out && !busy_out |->
        bidir_serial_line_out) else $error("idle line not ones");
    a_event_count: assert property (done_out |-> cyc_ff >=
        (n_ff + 1) * 12 && cyc_ff <= (n_ff + 3) * 12)
        else $error("transfer length wrong");
    a_link_clock: assert property (port_shift_clock_out ==
        sclk_in) else $error("shift clock differs");
endmodule
bind mw_link_master mw_link_master_monitor #(.AW(AW)) u_mon (.clk_in,
    .nrst_in, .sclk_in, .start_in, .word_count_in, .busy_out, .done_out,
    .port_shift_clock_out, .bidir_serial_line_out, .csel_n_out);
`default_nettype wire

// ===== test/mw_periph_model.sv
`default_nettype none
module mw_periph_model (
    // Link side
    input wire logic  sclk_in,
    input wire logic  nrst_in,
    input wire logic  csel_n_in,
    input wire logic  mosi_in,
    output var logic  miso_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Command bit 0 set marks a write; address is command bits 7:2
    logic [7:0]  mem [64];
    logic [15:0] sr;
    logic [7:0]  rdat;
    logic [3:0]  pos;
    initial for (int i = 0; i < 64; i++) mem[i] = 8'h00;
    // Bit position tracks the master's shifter whatever the reset phase
    always @(posedge sclk_in or negedge nrst_in) begin
        if (!nrst_in) pos <= 4'h0;
        else pos <= pos + 4'h1;
    end
    always @(negedge sclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sr = 16'h0000;
            rdat = 8'hFF;
            miso_out <= 1'b1;
        end else begin
            sr = {mosi_in, sr[15:1]};
            if (pos == 4'h7) rdat = mem[sr[15:10]];
            // Reply in the same frame as its command, upper byte
            if (!csel_n_in && pos >= 4'h8) miso_out <= rdat[pos[2:0]];
            else miso_out <= ~miso_out;
            if (pos == 4'hF && !csel_n_in && sr[0]) mem[sr[7:2]] <= sr[15:8];
        end
    end
endmodule
`default_nettype wire

// ===== test/serial_multiword_link_master_bench.sv
`default_nettype none
module serial_multiword_link_master_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_in = 0, sclk_in = 0, nrst_in = 0, start_in = 0;
    logic       read_in = 0, wr_we_in = 0, miso, mosi, sclk_o, csel_n;
    logic [7:0] cmd_in = 0, cnt_in = 0, wa = 0, wd = 0, ra = 0, rd;
    logic       busy, done;
    int         bad_count = 0, samples_checked = 0, n, a;
    int         mem_m [64];
    always #20 clk_in = ~clk_in;
    initial #7 forever #15 sclk_in = ~sclk_in;
    mw_link_master dut (.clk_in, .nrst_in, .sclk_in, .start_in, .read_in,
        .command_byte_in(cmd_in), .word_count_in(cnt_in), .busy_out(busy),
        .done_out(done), .wr_we_in, .wr_addr_in(wa), .wr_data_in(wd),
        .rd_addr_in(ra), .rd_data_out(rd), .port_shift_clock_out(sclk_o),
        .bidir_serial_line_out(mosi), .bidir_serial_line_in(miso),
        .csel_n_out(csel_n));
    mw_periph_model peri (.sclk_in(sclk_o), .nrst_in, .csel_n_in(csel_n),
        .mosi_in(mosi), .miso_out(miso));
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("unexpected %s exp %h seen %h", what, exp, seen);
            bad_count++;
        end
    endtask
    task automatic tally_and_finish();
        if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Start held two cycles: the second is refused while busy
    task automatic run(logic rd_op, logic [7:0] cmd, int words);
        int k;
        @(posedge clk_in);
        start_in <= 1'b1;
        read_in <= rd_op;
        cmd_in <= cmd;
        cnt_in <= 8'(words);
        repeat (2) @(posedge clk_in);
        start_in <= 1'b0;
        if (words == 0) begin
            check("busy on empty start", {7'h00, busy}, 8'h00);
        end else begin
            for (k = 0; k < 3000 && done !== 1'b1; k++) @(posedge clk_in);
            if (k == 3000) begin
                bad_count++;
                tally_and_finish();
            end
            @(posedge clk_in);
            check("busy after done", {7'h00, busy}, 8'h00);
            check("select after done", {7'h00, csel_n}, 8'h01);
        end
    endtask
    initial begin
        void'($urandom(32'h4541));
        foreach (mem_m[i]) mem_m[i] = 0;
        repeat (3) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        check("select idle", {7'h00, csel_n}, 8'h01);
        run(1'b0, 8'h05, 0);
        for (int t = 0; t < 5; t++) begin
            n = (t == 0) ? 1 : 1 + $urandom % 6;
            a = $urandom % 56;
            for (int i = 0; i < n; i++) begin
                @(posedge clk_in);
                wr_we_in <= 1'b1;
                wa <= 8'(i);
                wd <= 8'($urandom);
                #1 mem_m[a+i] = wd;
            end
            @(posedge clk_in);
            wr_we_in <= 1'b0;
            run(1'b0, {6'(a), 2'b01}, n);
            run(1'b1, {6'(a), 2'b00}, n);
            for (int i = 0; i < n; i++) begin
                @(posedge clk_in);
                ra <= 8'(i);
                repeat (2) @(posedge clk_in);
                check("read word", rd, 8'(mem_m[a+i]));
            end
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
